// >>> cfc_bank.sv
// core feature disable and clock gate override control bank on the csr port
`timescale 1ns/100ps
`default_nettype none
module cfc_bank #(
   parameter bit BUS_IS_AXI4 = 1'b0
) (
   input  wire logic                                clock,
   input  wire logic                                reset,
   // csr instruction port
   input  wire cfc_pkg::cfc_csr_req_t               csr_req,
   output logic                                     csr_hit,
   output logic                                     csr_rvalid,
   output logic      [cfc_pkg::DATA_W-1:0]          csr_rdata,
   output logic                                     csr_miss,
   // fence tracking
   input  wire logic                                fence_i_done,
   output logic                                     feature_write_unfenced,
   // feature controls to the core units
   output cfc_pkg::cfc_features_t                   features,
   output logic      [cfc_pkg::DATA_W-1:0]          feature_disable_control,
   output logic      [cfc_pkg::DATA_W-1:0]          clock_gate_override,
   // clock gating
   input  wire logic [cfc_pkg::CG_UNITS-1:0]        unit_busy,
   output logic      [cfc_pkg::CG_UNITS-1:0]        unit_clock_en
);

   ////////////////////////////////////////////////////////////////////////////
   // address decode and operation merge

   function automatic logic addr_is(input logic [cfc_pkg::CSR_ADDR_W-1:0] addr,
                                    input logic [cfc_pkg::CSR_ADDR_W-1:0] target);
      addr_is = (addr == target);
   endfunction

   // csrrw/csrrs/csrrc all reduce to a merge of old and written bits
   function automatic logic [cfc_pkg::DATA_W-1:0] merge(input cfc_pkg::cfc_op_t          op,
                                                        input logic [cfc_pkg::DATA_W-1:0] old_value,
                                                        input logic [cfc_pkg::DATA_W-1:0] bits);
      case (op)
         cfc_pkg::CFC_OP_WRITE: merge = bits;
         cfc_pkg::CFC_OP_SET:   merge = old_value | bits;
         cfc_pkg::CFC_OP_CLEAR: merge = old_value & ~bits;
         default:               merge = old_value; // unknown op leaves value untouched
      endcase
   endfunction

   wire logic hit_fd = csr_req.valid & addr_is(csr_req.addr, cfc_pkg::FEATURE_DISABLE_CONTROL_ADDR);
   wire logic hit_cg = csr_req.valid & addr_is(csr_req.addr, cfc_pkg::CLOCK_GATE_OVERRIDE_ADDR);
   wire logic write_fd = hit_fd & csr_req.write;
   wire logic write_cg = hit_cg & csr_req.write;

   wire logic [cfc_pkg::DATA_W-1:0] next_fd = merge(csr_req.op, feature_disable_control, csr_req.wdata);
   wire logic [cfc_pkg::DATA_W-1:0] next_cg = merge(csr_req.op, clock_gate_override, csr_req.wdata);

   // handshake answer is combinational so the core can raise illegal-instruction in the same cycle
   assign csr_hit = hit_fd | hit_cg;

   ////////////////////////////////////////////////////////////////////////////
   // the two registers

   // posted-store blocking reset depends on the bus the core is built with
   localparam logic [cfc_pkg::DATA_W-1:0] FD_RESET =
      BUS_IS_AXI4 ? cfc_pkg::FD_RESET_AXI4 : cfc_pkg::FD_RESET_BASE;

   cfc_warl_reg #(
      .WIDTH       (cfc_pkg::DATA_W),
      .WRITE_MASK  (cfc_pkg::FD_WRITE_MASK),
      .RESET_VALUE (FD_RESET)
   ) u_feature_disable (
      .clock       (clock),
      .reset       (reset),
      .write_en    (write_fd),
      .write_value (next_fd),
      .value       (feature_disable_control)
   );

   cfc_warl_reg #(
      .WIDTH       (cfc_pkg::DATA_W),
      .WRITE_MASK  (cfc_pkg::CG_WRITE_MASK),
      .RESET_VALUE (cfc_pkg::CG_RESET)
   ) u_clock_gate_override (
      .clock       (clock),
      .reset       (reset),
      .write_en    (write_cg),
      .write_value (next_cg),
      .value       (clock_gate_override)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read answer: registered, returns the value before any write in the same request

   wire logic [cfc_pkg::DATA_W-1:0] read_select =
      hit_fd ? feature_disable_control :
      hit_cg ? clock_gate_override : '0;

   always_ff @(posedge clock) begin
      if (reset) begin
         csr_rvalid <= 1'b0;
         csr_rdata  <= '0;
         csr_miss   <= 1'b0;
      end else begin
         csr_rvalid <= csr_hit;
         csr_rdata  <= read_select;
         csr_miss   <= csr_req.valid & ~csr_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fence tracking: flags a feature change not yet followed by fence.i

   // a write in the same cycle as a fence wins, since that fence ran before the write
   always_ff @(posedge clock) begin
      if (reset) begin
         feature_write_unfenced <= 1'b0;
      end else if (write_fd) begin
         feature_write_unfenced <= 1'b1;
      end else if (fence_i_done) begin
         feature_write_unfenced <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // level controls to the units, straight from the register flops except the side-effect load block, which is fixed high

   assign features.dma_qos                 =
      feature_disable_control[cfc_pkg::FD_DMA_QOS_LSB +: cfc_pkg::FD_DMA_QOS_W];
   assign features.single_issue            = feature_disable_control[cfc_pkg::FD_SINGLE_ISSUE];
   assign features.ecc_check_off           = feature_disable_control[cfc_pkg::FD_ECC_CHECK_OFF];
   assign features.alu2_off                = feature_disable_control[cfc_pkg::FD_ALU2_OFF];
   assign features.side_effect_store_block = feature_disable_control[cfc_pkg::FD_SE_STORE_BLOCK];
   // side-effect loads block regardless of any bit, so this level is fixed high
   assign features.side_effect_load_block  = 1'b1;
   assign features.blocking_load_div       = feature_disable_control[cfc_pkg::FD_BLOCKING_LD_DIV];
   assign features.fast_div_off            = feature_disable_control[cfc_pkg::FD_FAST_DIV_OFF];
   assign features.branch_predict_off      = feature_disable_control[cfc_pkg::FD_BRANCH_PRED_OFF];
   assign features.write_buffer_merge_off  = feature_disable_control[cfc_pkg::FD_MERGE_OFF];
   assign features.pipeline_off            = feature_disable_control[cfc_pkg::FD_PIPELINE_OFF];

   ////////////////////////////////////////////////////////////////////////////
   // clock gate enables per unit

   cfc_gate_ctrl #(
      .UNITS         (cfc_pkg::CG_UNITS)
   ) u_gate_ctrl (
      .clock         (clock),
      .reset         (reset),
      .unit_busy     (unit_busy),
      .override      (clock_gate_override[cfc_pkg::CG_UNITS-1:0]),
      .unit_clock_en (unit_clock_en)
   );

endmodule
`default_nettype wire

// >>> cfc_bank_monitor.sv
// concurrent checks on the ports of the feature disable and clock gate override bank
`timescale 1ns/100ps
`default_nettype none
module cfc_bank_monitor #(
   parameter bit BUS_IS_AXI4 = 1'b0
) (
   input wire logic                         clock,
   input wire logic                         reset,
   input wire cfc_pkg::cfc_csr_req_t        csr_req,
   input wire logic                         csr_hit,
   input wire logic                         csr_rvalid,
   input wire logic [cfc_pkg::DATA_W-1:0]   csr_rdata,
   input wire logic                         csr_miss,
   input wire logic                         feature_write_unfenced,
   input wire cfc_pkg::cfc_features_t       features,
   input wire logic [cfc_pkg::DATA_W-1:0]   feature_disable_control,
   input wire logic [cfc_pkg::DATA_W-1:0]   clock_gate_override,
   input wire logic [cfc_pkg::CG_UNITS-1:0] unit_busy,
   input wire logic [cfc_pkg::CG_UNITS-1:0] unit_clock_en
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // address decode shared by the checks
   wire logic cg_sel = csr_req.addr == 12'h7F8;
   wire logic [31:0] fdc = feature_disable_control;
   sequence fd_write_s;
      csr_hit && csr_req.write && csr_req.addr == 12'h7F9;
   endsequence
   sequence plain_write_s;
      csr_hit && csr_req.write && csr_req.op == cfc_pkg::CFC_OP_WRITE;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   hit_decode_a: assert property (csr_hit == (csr_req.valid && (cg_sel || csr_req.addr == 12'h7F9)))
      else $error("csr hit decode wrong");
   write_value_a: assert property (plain_write_s |=> ($past(cg_sel) ? clock_gate_override : fdc) ==
      ($past(csr_req.wdata) & ($past(cg_sel) ? 32'h0000_01FF : 32'h0007_05FD))) else $error("write value wrong");
   read_answer_a: assert property (csr_hit |=> csr_rvalid && !csr_miss &&
      csr_rdata == ($past(cg_sel) ? $past(clock_gate_override) : $past(fdc))) else $error("read answer wrong");
   miss_pulse_a: assert property (csr_req.valid && !csr_hit |=> csr_miss && !csr_rvalid && csr_rdata == 32'h0)
      else $error("unmapped access answer wrong");
   reserved_zero_a: assert property ((fdc & ~32'h0007_05FD) == 32'h0 &&
      (clock_gate_override & ~32'h0000_01FF) == 32'h0) else $error("reserved bit set");
   field_map_a: assert property (features == {fdc[18:16], fdc[10], fdc[8:6], 1'b1, fdc[5:2], fdc[0]})
      else $error("feature outputs differ from register");
   hold_value_a: assert property (!(csr_hit && csr_req.write) |=> $stable(fdc) && $stable(clock_gate_override))
      else $error("register changed without write");
   gate_enable_a: assert property (!$past(reset) |-> unit_clock_en == $past(unit_busy | clock_gate_override))
      else $error("clock enable wrong");
   unfenced_flag_a: assert property (fd_write_s |=> feature_write_unfenced)
      else $error("unfenced flag not set");
   reset_value_a: assert property ($fell(reset) |-> clock_gate_override == 32'h0 &&
      fdc == (BUS_IS_AXI4 ? 32'h0007_0040 : 32'h0007_0000)) else $error("reset value wrong");
endmodule
bind cfc_bank cfc_bank_monitor #(.BUS_IS_AXI4(BUS_IS_AXI4)) i_mon (.clock(clock), .reset(reset), .csr_req(csr_req),
   .csr_hit(csr_hit), .csr_rvalid(csr_rvalid), .csr_rdata(csr_rdata), .csr_miss(csr_miss),
   .feature_write_unfenced(feature_write_unfenced), .features(features),
   .feature_disable_control(feature_disable_control), .clock_gate_override(clock_gate_override),
   .unit_busy(unit_busy), .unit_clock_en(unit_clock_en));
`default_nettype wire

// >>> cfc_core_model.sv
// core side model: issues csr instructions and fence completions
`timescale 1ns/100ps
`default_nettype none
module cfc_core_model (
   input  wire logic                       clock,
   input  wire logic                       csr_rvalid,
   input  wire logic [cfc_pkg::DATA_W-1:0] csr_rdata,
   input  wire logic                       csr_miss,
   output var  cfc_pkg::cfc_csr_req_t      csr_req,
   output var  logic                       fence_i_done
);
   initial begin
      csr_req = '0;
      fence_i_done = 1'b0;
   end
   // request stands for the one edge that takes it; released fields flip so stale data never looks valid
   task automatic access(input logic wr, input cfc_pkg::cfc_op_t op, input logic [11:0] addr,
                         input logic [31:0] wdata, output logic [31:0] rdata, output logic [1:0] resp);
      @(posedge clock);
      csr_req <= '{1'b1, wr, op, addr, wdata};
      @(posedge clock);
      csr_req <= '{1'b0, ~wr, op, ~addr, ~wdata};
      #1;
      rdata = csr_rdata;
      resp = {csr_miss, csr_rvalid};
   endtask
   // fence completion pulse, issued around every feature register write
   task automatic fence();
      @(posedge clock);
      fence_i_done <= 1'b1;
      @(posedge clock);
      fence_i_done <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> cfc_gate_ctrl.sv
// per-unit clock enables: a unit clocks when busy or when its override is set
`timescale 1ns/100ps
`default_nettype none
module cfc_gate_ctrl #(
   parameter int unsigned UNITS = 9
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic [UNITS-1:0] unit_busy,
   input  wire logic [UNITS-1:0] override,
   output logic      [UNITS-1:0] unit_clock_en
);

   initial begin
      if (UNITS < 1) begin
         $error("cfc_gate_ctrl: at least one unit is needed");
      end
   end

   // registered so the gate cells see a clean level; busy is therefore one cycle late,
   // which the units must cover with their own lead time
   for (genvar u = 0; u < UNITS; u++) begin : g_unit
      wire logic next_en = unit_busy[u] | override[u];
      always_ff @(posedge clock) begin
         if (reset) begin
            unit_clock_en[u] <= 1'b0;
         end else begin
            unit_clock_en[u] <= next_en;
         end
      end
   end

endmodule
`default_nettype wire

// >>> cfc_pkg.sv
// constants, types and field layout of the core feature and clock gate control bank
//
// How it works
// - reserved bits read zero, writes ignored
// - any write accepted, only legal values kept
// - feature register at 0x7F9, features enabled
// - bits 18:16 hold DMA QoS, reset 7
// - bit 10 set forces single issue
// - bit 8 set turns off memory ECC
// - bit 7 set disables secondary ALU
// - bit 6 set makes side-effect stores block
// - side-effect loads always block the pipeline
// - bit 6 resets 0 AHB-Lite, 1 AXI4
// - bit 5 set forces blocking loads, divides
// - bit 4 set disables fast divide
// - bit 3 set disables prediction and return stack
// - bit 2 set stops write buffer merging
// - bit 0 set turns pipelining off
// - override register at 0x7F8, resets all clear
// - bits 8..4 force core unit clocks on
// - bits 3..0 force bus, interrupt, memory clocks
package cfc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // csr numbers and widths
   localparam int unsigned CSR_ADDR_W = 12;
   localparam int unsigned DATA_W     = 32;
   localparam logic [CSR_ADDR_W-1:0] CLOCK_GATE_OVERRIDE_ADDR     = 12'h7F8;
   localparam logic [CSR_ADDR_W-1:0] FEATURE_DISABLE_CONTROL_ADDR = 12'h7F9;

   ////////////////////////////////////////////////////////////////////////////
   // feature disable field positions
   localparam int unsigned FD_DMA_QOS_LSB      = 16;
   localparam int unsigned FD_DMA_QOS_W        = 3;
   localparam int unsigned FD_SINGLE_ISSUE     = 10;
   localparam int unsigned FD_ECC_CHECK_OFF    = 8;
   localparam int unsigned FD_ALU2_OFF         = 7;
   localparam int unsigned FD_SE_STORE_BLOCK   = 6;
   localparam int unsigned FD_BLOCKING_LD_DIV  = 5;
   localparam int unsigned FD_FAST_DIV_OFF     = 4;
   localparam int unsigned FD_BRANCH_PRED_OFF  = 3;
   localparam int unsigned FD_MERGE_OFF        = 2;
   localparam int unsigned FD_PIPELINE_OFF     = 0;

   // writable bits: 18:16, 10, 8:2, 0
   localparam logic [DATA_W-1:0] FD_WRITE_MASK   = 32'h0007_05FD;
   localparam logic [DATA_W-1:0] FD_RESET_BASE   = 32'h0007_0000;
   localparam logic [DATA_W-1:0] FD_RESET_AXI4   = 32'h0007_0040;

   ////////////////////////////////////////////////////////////////////////////
   // clock gate override field positions
   localparam int unsigned CG_UNITS       = 9;
   localparam int unsigned CG_MISC        = 8;
   localparam int unsigned CG_DECODE      = 7;
   localparam int unsigned CG_EXECUTE     = 6;
   localparam int unsigned CG_FETCH       = 5;
   localparam int unsigned CG_LOAD_STORE  = 4;
   localparam int unsigned CG_BUS         = 3;
   localparam int unsigned CG_INT_CTRL    = 2;
   localparam int unsigned CG_DATA_MEM    = 1;
   localparam int unsigned CG_INSTR_MEM   = 0;
   localparam logic [DATA_W-1:0] CG_WRITE_MASK = 32'h0000_01FF;
   localparam logic [DATA_W-1:0] CG_RESET      = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      CFC_OP_WRITE,
      CFC_OP_SET,
      CFC_OP_CLEAR
   } cfc_op_t;

   typedef struct packed {
      logic                  valid;
      logic                  write;
      cfc_op_t               op;
      logic [CSR_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     wdata;
   } cfc_csr_req_t;

   typedef struct packed {
      logic [FD_DMA_QOS_W-1:0] dma_qos;
      logic                    single_issue;
      logic                    ecc_check_off;
      logic                    alu2_off;
      logic                    side_effect_store_block;
      logic                    side_effect_load_block;
      logic                    blocking_load_div;
      logic                    fast_div_off;
      logic                    branch_predict_off;
      logic                    write_buffer_merge_off;
      logic                    pipeline_off;
   } cfc_features_t;

endpackage

// >>> cfc_warl_reg.sv
// one masked read/write control register that keeps only its legal bits
`timescale 1ns/100ps
`default_nettype none
module cfc_warl_reg #(
   parameter int unsigned       WIDTH       = 32,
   parameter logic [WIDTH-1:0]  WRITE_MASK  = '1,
   parameter logic [WIDTH-1:0]  RESET_VALUE = '0
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             write_en,
   input  wire logic [WIDTH-1:0] write_value,
   output logic      [WIDTH-1:0] value
);

   initial begin
      if ((RESET_VALUE & ~WRITE_MASK) != '0) begin
         $error("cfc_warl_reg: reset value sets reserved bits");
      end
   end

   // reserved bits never load, so they read zero whatever is written
   always_ff @(posedge clock) begin
      if (reset) begin
         value <= RESET_VALUE;
      end else if (write_en) begin
         value <= write_value & WRITE_MASK;
      end
   end

endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the feature disable and clock gate override bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic                  clock, reset, fence_i_done, csr_hit, csr_rvalid, csr_miss, unfenced;
   logic [8:0]            unit_busy, clk_en;
   logic [31:0]           csr_rdata, fdc, cgo, axi_fdc, rd;
   logic [1:0]            resp;
   cfc_pkg::cfc_csr_req_t csr_req;
   cfc_pkg::cfc_features_t features;
   logic [31:0]           pat [4] = '{32'hFFFF_FFFF, 32'hFFF8_FA02, 32'h0005_0000, 32'h0000_0040};
   int                    err_total = 0;
   int                    total_checks = 0;
   cfc_bank i_dut (.clock(clock), .reset(reset), .csr_req(csr_req), .csr_hit(csr_hit), .csr_rvalid(csr_rvalid),
      .csr_rdata(csr_rdata), .csr_miss(csr_miss), .fence_i_done(fence_i_done), .feature_write_unfenced(unfenced),
      .features(features), .feature_disable_control(fdc), .clock_gate_override(cgo), .unit_busy(unit_busy),
      .unit_clock_en(clk_en));
   // second build only shows the bus dependent reset value, so its inputs stay idle
   cfc_bank #(.BUS_IS_AXI4(1'b1)) i_dut_axi (.clock(clock), .reset(reset), .csr_req('0), .csr_hit(), .csr_rvalid(),
      .csr_rdata(), .csr_miss(), .fence_i_done(1'b0), .feature_write_unfenced(), .features(),
      .feature_disable_control(axi_fdc), .clock_gate_override(), .unit_busy(9'h0), .unit_clock_en());
   cfc_core_model i_core (.clock(clock), .csr_rvalid(csr_rvalid), .csr_rdata(csr_rdata), .csr_miss(csr_miss),
      .csr_req(csr_req), .fence_i_done(fence_i_done));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      if (err_total == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // feature outputs expected from a register value
   function automatic logic [31:0] exp_feat(input logic [31:0] v);
      return {19'h0, v[18:16], v[10], v[8:6], 1'b1, v[5:2], v[0]};
   endfunction
   task automatic wr(input cfc_pkg::cfc_op_t op, input logic [11:0] addr, input logic [31:0] data);
      logic fd;
      fd = addr == 12'h7F9;
      if (fd) i_core.fence();
      i_core.access(1'b1, op, addr, data, rd, resp);
      if (fd) cmp({31'h0, unfenced}, 32'h1);
      if (fd) i_core.fence();
   endtask
   task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
      i_core.access(1'b0, cfc_pkg::CFC_OP_WRITE, addr, 32'h0, rd, resp);
      cmp({30'h0, resp}, 32'h1);
      cmp(rd, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      unit_busy = 9'h0;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      rd_chk(12'h7F9, 32'h0007_0000);
      rd_chk(12'h7F8, 32'h0);
      cmp(axi_fdc, 32'h0007_0040);
      cmp(32'(features), exp_feat(32'h0007_0000));
      // all ones, reserved only, qos value, store blocking alone
      foreach (pat[i]) begin
         wr(cfc_pkg::CFC_OP_WRITE, 12'h7F9, pat[i]);
         rd_chk(12'h7F9, pat[i] & 32'h0007_05FD);
         cmp(32'(features), exp_feat(pat[i] & 32'h0007_05FD));
      end
      #1 cmp({31'h0, unfenced}, 32'h0);
      // each disable bit alone drives only its own control
      for (int b = 0; b < 11; b++) begin
         if (b != 1 && b != 9) begin
            wr(cfc_pkg::CFC_OP_WRITE, 12'h7F9, 32'h1 << b);
            cmp(32'(features), exp_feat(32'h1 << b));
         end
      end
      wr(cfc_pkg::CFC_OP_WRITE, 12'h7F8, 32'hFFFF_FFFF);
      rd_chk(12'h7F8, 32'h0000_01FF);
      wr(cfc_pkg::CFC_OP_CLEAR, 12'h7F8, 32'h0000_00F0);
      rd_chk(12'h7F8, 32'h0000_010F);
      wr(cfc_pkg::CFC_OP_SET, 12'h7F8, 32'h0000_0010);
      rd_chk(12'h7F8, 32'h0000_011F);
      @(posedge clock);
      unit_busy <= 9'h0A0;
      @(posedge clock);
      #1 cmp({23'h0, clk_en}, 32'h0000_01BF);
      // an undefined operation code must leave the register as it was
      i_core.access(1'b1, cfc_pkg::cfc_op_t'(2'h3), 12'h7F8, 32'h0, rd, resp);
      cmp(rd, 32'h0000_011F);
      i_core.access(1'b1, cfc_pkg::CFC_OP_WRITE, 12'h7FA, 32'hFFFF_FFFF, rd, resp);
      cmp({30'h0, resp}, 32'h2);
      cmp(rd, 32'h0);
      rd_chk(12'h7F8, 32'h0000_011F);
      // reset in mid-run restores both registers
      @(posedge clock);
      reset <= 1'b1;
      @(posedge clock);
      reset <= 1'b0;
      rd_chk(12'h7F9, 32'h0007_0000);
      rd_chk(12'h7F8, 32'h0);
      stop_test();
   end
   // the run needs well under a thousand cycles
   initial begin
      #20000;
      err_total++;
      stop_test();
   end
endmodule
`default_nettype wire
